// >>> fdx_pkg.sv
package fdx_pkg;

    // ==========================================================
    // operation codes
    // bit 4 set marks a single-flag op: [3:1] bit, [0] new value
    localparam logic [4:0] OP_NOP = 5'h00;
    localparam logic [4:0] OP_REGISTER_COPY = 5'h01;
    localparam logic [4:0] OP_REGISTER_PAIR_COPY = 5'h02;
    localparam logic [4:0] OP_IMMEDIATE_LOAD = 5'h03;
    localparam logic [4:0] OP_MEMORY_READ_INDIRECT = 5'h04;
    localparam logic [4:0] OP_MEMORY_READ_OFFSET = 5'h05;
    localparam logic [4:0] OP_MEMORY_READ_ABSOLUTE = 5'h06;
    localparam logic [4:0] OP_MEMORY_WRITE_INDIRECT = 5'h07;
    localparam logic [4:0] OP_MEMORY_WRITE_OFFSET = 5'h08;
    localparam int OP_FLAG_MARK = 4;
    localparam logic [4:0] OP_NEGATIVE_FLAG_LOWER = 5'h14;
    localparam logic [4:0] OP_NEGATIVE_FLAG_RAISE = 5'h15;
    localparam logic [4:0] OP_ZERO_FLAG_LOWER = 5'h12;
    localparam logic [4:0] OP_ZERO_FLAG_RAISE = 5'h13;
    localparam logic [4:0] OP_OVERFLOW_FLAG_LOWER = 5'h16;
    localparam logic [4:0] OP_OVERFLOW_FLAG_RAISE = 5'h17;
    localparam logic [4:0] OP_SIGNED_FLAG_LOWER = 5'h18;
    localparam logic [4:0] OP_SIGNED_FLAG_RAISE = 5'h19;
    localparam logic [4:0] OP_HALF_CARRY_LOWER = 5'h1a;
    localparam logic [4:0] OP_HALF_CARRY_RAISE = 5'h1b;
    localparam logic [4:0] OP_T_FLAG_LOWER = 5'h1c;
    localparam logic [4:0] OP_T_FLAG_RAISE = 5'h1d;
    localparam logic [4:0] OP_INTERRUPT_GLOBAL_OFF = 5'h1e;
    localparam logic [4:0] OP_INTERRUPT_GLOBAL_ON = 5'h1f;

    // ==========================================================
    // flag register bit positions
    localparam logic [2:0] FLAG_C = 3'h0;
    localparam logic [2:0] FLAG_Z = 3'h1;
    localparam logic [2:0] FLAG_N = 3'h2;
    localparam logic [2:0] FLAG_V = 3'h3;
    localparam logic [2:0] FLAG_S = 3'h4;
    localparam logic [2:0] FLAG_H = 3'h5;
    localparam logic [2:0] FLAG_T = 3'h6;
    localparam logic [2:0] FLAG_I = 3'h7;

    // ==========================================================
    // pointer selection and update modes
    localparam logic [1:0] PTR_X = 2'h0;
    localparam logic [1:0] PTR_Y = 2'h1;
    localparam logic [1:0] PTR_Z = 2'h2;
    localparam logic [4:0] PTR_X_LOW_REG = 5'h1a;
    localparam logic [1:0] MODE_PLAIN = 2'h0;
    localparam logic [1:0] MODE_POST_INC = 2'h1;
    localparam logic [1:0] MODE_PRE_DEC = 2'h2;

    // ==========================================================
    // reset values
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [7:0] REG_RESET = 8'h00;

    // one-hot execution states
    typedef enum logic [1:0] {
        STATE_IDLE = 2'b01,
        STATE_MEM = 2'b10
    } fdx_state_e;

endpackage : fdx_pkg

// >>> fdx_addr_unit.sv
`timescale 1ns/100ps

// ==========================================================
// effective address and pointer update for data memory ops
module fdx_addr_unit (
    input wire logic [15:0] ptr_val,
    input wire logic [1:0] mode,
    input wire logic [5:0] disp,
    input wire logic use_disp,
    input wire logic use_abs,
    input wire logic [15:0] abs_addr,
    output logic [15:0] eff_addr,
    output logic [15:0] new_ptr,
    output logic ptr_write
);

    logic [15:0] ptr_inc;
    logic [15:0] ptr_dec;
    logic [15:0] ptr_disp;

    // full 16-bit arithmetic so carries cross the register pair
    assign ptr_inc = ptr_val + 16'h0001;
    assign ptr_dec = ptr_val - 16'h0001;
    assign ptr_disp = ptr_val + {10'h000, disp};

    // address selection; displacement and absolute forms never write back
    always_comb begin
        eff_addr = ptr_val;
        new_ptr = ptr_val;
        ptr_write = 1'b0;
        if (use_abs) begin
            eff_addr = abs_addr;
        end else if (use_disp) begin
            eff_addr = ptr_disp;
        end else if (mode == fdx_pkg::MODE_POST_INC) begin
            new_ptr = ptr_inc;
            ptr_write = 1'b1;
        end else if (mode == fdx_pkg::MODE_PRE_DEC) begin
            eff_addr = ptr_dec;
            new_ptr = ptr_dec;
            ptr_write = 1'b1;
        end
    end

endmodule : fdx_addr_unit

// >>> fdx_exec.sv
`timescale 1ns/100ps

// Summary of operation
// - Flag raise/lower for I, T, N, Z, S changes only that bit, one cycle.
// - Overflow raise/lower writes V only, in one cycle.
// - Half carry raise/lower writes H only, in one cycle.
// - Indirect read loads Rd from pointer; post-inc bumps pointer; two cycles.
// - Pre-decrement read lowers pointer first, then loads from it; two cycles.
// - Offset read uses X, Y or Z plus q, pointer untouched; two cycles.
// - Absolute read loads Rd from address k; two cycles, flags kept.
// - Indirect write stores Rr at pointer; post-inc bumps pointer; two cycles.
// - Pre-decrement write lowers pointer first, then stores Rr; two cycles.
// - Offset write stores Rr at X, Y or Z plus q, pointer untouched.

module fdx_exec (
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic CE,
    input wire logic OP_VALID,
    input wire logic [4:0] OP,
    input wire logic [4:0] RD,
    input wire logic [4:0] RR,
    input wire logic [7:0] IMM,
    input wire logic [1:0] PTR_SEL,
    input wire logic [1:0] PTR_MODE,
    input wire logic [5:0] DISP,
    input wire logic [15:0] ABS_ADDR,
    output logic READY,
    output logic DONE,
    output logic [7:0] FLAGS,
    output logic [15:0] MEM_ADDR,
    output logic [7:0] MEM_WDATA,
    output logic MEM_RE,
    output logic MEM_WE,
    input wire logic [7:0] MEM_RDATA,
    input wire logic [4:0] REG_RADDR,
    output logic [7:0] REG_RDATA
);

    // ==========================================================
    // state
    typedef struct packed {
        fdx_pkg::fdx_state_e state;
        logic [31:0][7:0] regs;
        logic [7:0] flags;
        logic [15:0] mem_addr;
        logic [7:0] mem_wdata;
        logic mem_re;
        logic mem_we;
        logic [4:0] load_rd;
        logic done;
        logic [7:0] reg_rdata;
    } fdx_exec_s;

    fdx_exec_s s;
    fdx_exec_s next_s;

    logic [1:0] sel;
    logic [4:0] ptr_lo;
    logic [4:0] ptr_hi;
    logic [15:0] ptr_val;
    logic is_read;
    logic is_write;
    logic is_disp;
    logic is_abs;
    logic [15:0] eff_addr;
    logic [15:0] new_ptr;
    logic ptr_write;
    logic accept;
    logic [4:0] pair_rd;
    logic [4:0] pair_rr;

    // ==========================================================
    // pointer pair selection; a select of 3 is taken as Z
    assign sel = (PTR_SEL == 2'h3) ? fdx_pkg::PTR_Z : PTR_SEL;
    assign ptr_lo = fdx_pkg::PTR_X_LOW_REG + {2'h0, sel, 1'b0};
    assign ptr_hi = ptr_lo + 5'h01;
    assign ptr_val = {s.regs[ptr_hi], s.regs[ptr_lo]};

    // op classes
    assign is_read = (OP == fdx_pkg::OP_MEMORY_READ_INDIRECT)
                  || (OP == fdx_pkg::OP_MEMORY_READ_OFFSET)
                  || (OP == fdx_pkg::OP_MEMORY_READ_ABSOLUTE);
    assign is_write = (OP == fdx_pkg::OP_MEMORY_WRITE_INDIRECT)
                   || (OP == fdx_pkg::OP_MEMORY_WRITE_OFFSET);
    assign is_disp = (OP == fdx_pkg::OP_MEMORY_READ_OFFSET)
                  || (OP == fdx_pkg::OP_MEMORY_WRITE_OFFSET);
    assign is_abs = (OP == fdx_pkg::OP_MEMORY_READ_ABSOLUTE);
    assign pair_rd = {RD[4:1], 1'b0};
    assign pair_rr = {RR[4:1], 1'b0};

    fdx_addr_unit u_addr (
        .ptr_val(ptr_val),
        .mode(PTR_MODE),
        .disp(DISP),
        .use_disp(is_disp),
        .use_abs(is_abs),
        .abs_addr(ABS_ADDR),
        .eff_addr(eff_addr),
        .new_ptr(new_ptr),
        .ptr_write(ptr_write)
    );

    // ==========================================================
    // handshake: a new op is taken only while idle
    assign READY = (s.state == fdx_pkg::STATE_IDLE);
    assign accept = OP_VALID && READY;

    // next state
    always_comb begin
        next_s = s;
        next_s.done = 1'b0;
        next_s.reg_rdata = s.regs[REG_RADDR];
        case (s.state)
            fdx_pkg::STATE_IDLE: begin
                if (OP_VALID) begin
                    if (OP[fdx_pkg::OP_FLAG_MARK]) begin
                        // carry code is out of scope and finishes as a no-op
                        if (OP[3:1] != fdx_pkg::FLAG_C) begin
                            next_s.flags[OP[3:1]] = OP[0];
                        end
                        next_s.done = 1'b1;
                    end else if (is_read || is_write) begin
                        // pointer update lands with the address, so a
                        // pre-decrement is seen by the access itself
                        next_s.mem_addr = eff_addr;
                        next_s.mem_re = is_read;
                        next_s.mem_we = is_write;
                        next_s.mem_wdata = s.regs[RR];
                        next_s.load_rd = RD;
                        if (ptr_write && !is_disp && !is_abs) begin
                            next_s.regs[ptr_lo] = new_ptr[7:0];
                            next_s.regs[ptr_hi] = new_ptr[15:8];
                        end
                        next_s.state = fdx_pkg::STATE_MEM;
                    end else begin
                        case (OP)
                            fdx_pkg::OP_REGISTER_COPY: begin
                                next_s.regs[RD] = s.regs[RR];
                            end
                            fdx_pkg::OP_REGISTER_PAIR_COPY: begin
                                next_s.regs[pair_rd] = s.regs[pair_rr];
                                next_s.regs[pair_rd + 5'h01] =
                                    s.regs[pair_rr + 5'h01];
                            end
                            fdx_pkg::OP_IMMEDIATE_LOAD: begin
                                next_s.regs[RD] = IMM;
                            end
                            default: begin
                                next_s.regs = s.regs;
                            end
                        endcase
                        next_s.done = 1'b1;
                    end
                end
            end
            fdx_pkg::STATE_MEM: begin
                // second cycle: memory answers on the held address;
                // the loaded byte wins over a pointer update of Rd
                if (s.mem_re) begin
                    next_s.regs[s.load_rd] = MEM_RDATA;
                end
                next_s.mem_re = 1'b0;
                next_s.mem_we = 1'b0;
                next_s.done = 1'b1;
                next_s.state = fdx_pkg::STATE_IDLE;
            end
            default: begin
                next_s.state = fdx_pkg::STATE_IDLE;
            end
        endcase
    end

    // ==========================================================
    // registered state, frozen while the clock enable is low
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            s.state <= fdx_pkg::STATE_IDLE;
            s.regs <= {32{fdx_pkg::REG_RESET}};
            s.flags <= fdx_pkg::FLAGS_RESET;
            s.mem_addr <= 16'h0000;
            s.mem_wdata <= 8'h00;
            s.mem_re <= 1'b0;
            s.mem_we <= 1'b0;
            s.load_rd <= 5'h00;
            s.done <= 1'b0;
            s.reg_rdata <= 8'h00;
        end else if (CE) begin
            s <= next_s;
        end
    end

    assign DONE = s.done;
    assign FLAGS = s.flags;
    assign MEM_ADDR = s.mem_addr;
    assign MEM_WDATA = s.mem_wdata;
    assign MEM_RE = s.mem_re;
    assign MEM_WE = s.mem_we;
    assign REG_RDATA = s.reg_rdata;

    // ==========================================================
    // checks
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN || !CE);

    AST_FLAG_SINGLE: assert property (
        accept && OP[4] && (OP[3:1] != fdx_pkg::FLAG_C)
        |=> DONE && (FLAGS[$past(OP[3:1])] == $past(OP[0]))
            && READY)
        else $error("flag op did not finish in one cycle");

    AST_OVERFLOW_ONLY: assert property (
        accept && (OP[4:1] == {1'b1, fdx_pkg::FLAG_V})
        |=> FLAGS[3] == $past(OP[0])
            && {FLAGS[7:4], FLAGS[2:0]} == $past({FLAGS[7:4], FLAGS[2:0]}))
        else $error("overflow op touched other flags");

    AST_HALF_ONLY: assert property (
        accept && (OP[4:1] == {1'b1, fdx_pkg::FLAG_H})
        |=> FLAGS[5] == $past(OP[0])
            && {FLAGS[7:6], FLAGS[4:0]} == $past({FLAGS[7:6], FLAGS[4:0]}))
        else $error("half carry op touched other flags");

    AST_READ_TWO: assert property (
        accept && is_read
        |=> MEM_RE && !READY && !DONE ##1 DONE && READY && !MEM_RE
            && s.regs[$past(RD, 2)] == $past(MEM_RDATA)
            && $stable(FLAGS))
        else $error("memory read did not take two cycles");

    AST_PREDEC_ADDR: assert property (
        accept && (is_read || is_write) && !is_disp && !is_abs
            && PTR_MODE == fdx_pkg::MODE_PRE_DEC
        |=> MEM_ADDR == $past(ptr_val) - 16'h0001
            && {s.regs[$past(ptr_hi)], s.regs[$past(ptr_lo)]} == MEM_ADDR)
        else $error("pre-decrement address wrong");

    AST_DISP_ADDR: assert property (
        accept && is_disp
        |=> MEM_ADDR == $past(ptr_val) + {10'h000, $past(DISP)}
            && {s.regs[$past(ptr_hi)], s.regs[$past(ptr_lo)]}
               == $past(ptr_val))
        else $error("displacement address wrong or pointer moved");

    AST_ABS_ADDR: assert property (
        accept && is_abs |=> MEM_RE && MEM_ADDR == $past(ABS_ADDR))
        else $error("absolute address wrong");

    AST_WRITE_DATA: assert property (
        accept && is_write
        |=> MEM_WE && MEM_WDATA == $past(s.regs[RR]) ##1 !MEM_WE && DONE)
        else $error("store data or timing wrong");

    AST_COPY_ONE: assert property (
        accept && !OP[4] && !is_read && !is_write
        |=> DONE && READY && $stable(FLAGS))
        else $error("register op not single cycle or changed flags");

    AST_POSTINC_PTR: assert property (
        accept && (is_read || is_write) && !is_disp && !is_abs
            && PTR_MODE == fdx_pkg::MODE_POST_INC
        |=> MEM_ADDR == $past(ptr_val)
            && {s.regs[$past(ptr_hi)], s.regs[$past(ptr_lo)]}
               == $past(ptr_val) + 16'h0001)
        else $error("post-increment pointer wrong");

endmodule : fdx_exec

// >>> fdx_mem_model.sv
`timescale 1ns/100ps

// ==========================================================
// data memory model: combinational read, write at the edge
module fdx_mem_model (
    input wire logic clk,
    input wire logic [15:0] addr,
    input wire logic [7:0] wdata,
    input wire logic re,
    input wire logic we,
    output logic [7:0] rdata
);
    logic [7:0] mem [0:65535];
    logic [7:0] held;

    // preset mixes both address bytes with 5a so a wrong address shows up
    initial begin
        for (int i = 0; i < 65536; i++) begin
            mem[i] = 8'(i) ^ 8'(i >> 8) ^ 8'h5a;
        end
    end

    // outside a read the bus shows the inverse of the last byte,
    // so a late sample can never pick up a stale match
    always_comb rdata = re ? mem[addr] : ~held;

    // plain always: the preset above also writes the array
    always @(posedge clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        if (re) begin
            held <= mem[addr];
        end
    end
endmodule : fdx_mem_model

// >>> fdx_tb.sv
`timescale 1ns/100ps

// ==========================================================
// bench for flag and data transfer execution
module testbench;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic op_valid = 1'b0;
    logic [4:0] op = '0;
    logic [4:0] rd = '0;
    logic [4:0] rr = '0;
    logic [4:0] reg_raddr = '0;
    logic [7:0] imm = '0;
    logic [1:0] ptr_sel = '0;
    logic [1:0] ptr_mode = '0;
    logic [5:0] disp = '0;
    logic [15:0] abs_addr = '0;
    logic ready, done, mem_re, mem_we, s_re, s_we, s_rdy;
    logic [7:0] flags, mem_wdata, mem_rdata, reg_rdata, v_imm, exp_fl;
    logic [15:0] mem_addr, s_addr, v_abs;
    logic [5:0] v_disp;
    logic [7:0] exp_r [0:31];
    int fails = 0;
    int checks = 0;
    int cycles = 0;

    always #20 clk = ~clk;

    // hang guard: the whole run needs well under 2000 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            fails++;
            $display("unexpected run length expected 1999 seen 2000");
            tally_and_finish();
        end
    end

    fdx_exec dut_u (.CLK(clk), .RSTN(rstn), .CE(1'b1), .OP_VALID(op_valid),
        .OP(op), .RD(rd), .RR(rr), .IMM(imm), .PTR_SEL(ptr_sel),
        .PTR_MODE(ptr_mode), .DISP(disp), .ABS_ADDR(abs_addr),
        .READY(ready), .DONE(done), .FLAGS(flags), .MEM_ADDR(mem_addr),
        .MEM_WDATA(mem_wdata), .MEM_RE(mem_re), .MEM_WE(mem_we),
        .MEM_RDATA(mem_rdata), .REG_RADDR(reg_raddr),
        .REG_RDATA(reg_rdata));

    fdx_mem_model mem_u (.clk(clk), .addr(mem_addr), .wdata(mem_wdata),
        .re(mem_re), .we(mem_we), .rdata(mem_rdata));

    // ==========================================================
    // shared tasks
    task chk(input string what, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e) begin
            fails++;
            $display("unexpected %s expected %h seen %h", what, e, g);
        end
    endtask : chk

    // one request, then count cycles to completion
    task run(input logic [4:0] o, d, r, input logic [1:0] p, m,
             input int cyc);
        int n;
        @(posedge clk);
        op_valid <= 1'b1;
        op <= o;
        rd <= d;
        rr <= r;
        ptr_sel <= p;
        ptr_mode <= m;
        imm <= v_imm;
        disp <= v_disp;
        abs_addr <= v_abs;
        n = 0;
        // the accept edge is the first one counted
        do begin
            @(posedge clk);
            op_valid <= 1'b0;
            #1;
            n++;
            if (n == 1) begin
                s_re = mem_re;
                s_we = mem_we;
                s_addr = mem_addr;
                s_rdy = ready;
            end
        end while (done !== 1'b1 && n < 8);
        chk("cycles", 16'(cyc), 16'(n));
        chk("flags", 16'(exp_fl), 16'(flags));
        chk("ready", 16'(cyc == 1), 16'(s_rdy));
        if (cyc == 1) begin
            chk("strobes", 16'h0000, 16'({s_re, s_we}));
        end
    endtask : run

    // register peek answers one cycle after the index
    task peek(input logic [4:0] i);
        @(posedge clk);
        reg_raddr <= i;
        @(posedge clk);
        #1;
        chk("register", 16'(exp_r[i]), 16'(reg_rdata));
    endtask : peek

    task load_imm(input logic [4:0] d, input logic [7:0] v);
        v_imm = v;
        exp_r[d] = v;
        run(fdx_pkg::OP_IMMEDIATE_LOAD, d, 5'h00, 2'h0, 2'h0, 1);
    endtask : load_imm

    // memory op: register is Rd for reads and Rr for writes
    task xfer(input logic [4:0] o, dr, input logic [1:0] p, m,
              input logic [15:0] a);
        logic wr;
        wr = o inside {fdx_pkg::OP_MEMORY_WRITE_INDIRECT,
                       fdx_pkg::OP_MEMORY_WRITE_OFFSET};
        if (!wr) begin
            exp_r[dr] = mem_u.mem[a];
        end
        run(o, dr, dr, p, m, 2);
        chk("address", a, s_addr);
        chk("strobes", wr ? 16'h0001 : 16'h0002, 16'({s_re, s_we}));
        if (wr) begin
            chk("memory", 16'(exp_r[dr]), 16'(mem_u.mem[a]));
        end else begin
            peek(dr);
        end
    endtask : xfer

    task tally_and_finish;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : tally_and_finish

    // ==========================================================
    // test sequence
    initial begin
        exp_fl = '0;
        v_imm = '0;
        v_disp = '0;
        v_abs = '0;
        for (int i = 0; i < 32; i++) begin
            exp_r[i] = '0;
        end
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        // raise all but C, lower them, raise them: neighbours must hold
        for (int p = 0; p < 3; p++) begin
            for (int b = 1; b < 8; b++) begin
                exp_fl[b] = (p != 1);
                run({1'b1, 3'(b), 1'(p != 1)}, '0, '0, '0, '0, 1);
            end
        end
        run(5'h10, '0, '0, '0, '0, 1);
        run(5'h11, '0, '0, '0, '0, 1);
        run(fdx_pkg::OP_NOP, '0, '0, '0, '0, 1);
        $display("test flags done");
        // pointers: X=00ff, Y=0100, Z=2010
        load_imm(5'h1a, 8'hff);
        load_imm(5'h1b, 8'h00);
        load_imm(5'h1c, 8'h00);
        load_imm(5'h1d, 8'h01);
        load_imm(5'h1e, 8'h10);
        load_imm(5'h1f, 8'h20);
        xfer(fdx_pkg::OP_MEMORY_READ_INDIRECT, 5'h01, fdx_pkg::PTR_X, fdx_pkg::MODE_POST_INC, 16'h00ff);
        exp_r[26] = 8'h00;
        exp_r[27] = 8'h01;
        xfer(fdx_pkg::OP_MEMORY_READ_INDIRECT, 5'h02, fdx_pkg::PTR_Y, fdx_pkg::MODE_PRE_DEC, 16'h00ff);
        exp_r[28] = 8'hff;
        exp_r[29] = 8'h00;
        v_disp = 6'h3f;
        xfer(fdx_pkg::OP_MEMORY_READ_OFFSET, 5'h03, fdx_pkg::PTR_Z, fdx_pkg::MODE_PLAIN, 16'h204f);
        v_abs = 16'hfffe;
        xfer(fdx_pkg::OP_MEMORY_READ_ABSOLUTE, 5'h04, fdx_pkg::PTR_X, fdx_pkg::MODE_PLAIN, 16'hfffe);
        xfer(fdx_pkg::OP_MEMORY_READ_INDIRECT, 5'h05, fdx_pkg::PTR_X, fdx_pkg::MODE_PLAIN, 16'h0100);
        $display("test loads done");
        xfer(fdx_pkg::OP_MEMORY_WRITE_INDIRECT, 5'h04, fdx_pkg::PTR_Z, fdx_pkg::MODE_POST_INC, 16'h2010);
        exp_r[30] = 8'h11;
        xfer(fdx_pkg::OP_MEMORY_WRITE_INDIRECT, 5'h03, fdx_pkg::PTR_X, fdx_pkg::MODE_PRE_DEC, 16'h00ff);
        exp_r[26] = 8'hff;
        exp_r[27] = 8'h00;
        v_disp = 6'h05;
        xfer(fdx_pkg::OP_MEMORY_WRITE_OFFSET, 5'h02, fdx_pkg::PTR_Y, fdx_pkg::MODE_PLAIN, 16'h0104);
        xfer(fdx_pkg::OP_MEMORY_READ_OFFSET, 5'h06, fdx_pkg::PTR_Y, fdx_pkg::MODE_PLAIN, 16'h0104);
        $display("test stores done");
        run(fdx_pkg::OP_REGISTER_COPY, 5'h07, 5'h06, '0, '0, 1);
        exp_r[7] = exp_r[6];
        run(fdx_pkg::OP_REGISTER_PAIR_COPY, 5'h08, 5'h1a, '0, '0, 1);
        exp_r[8] = exp_r[26];
        exp_r[9] = exp_r[27];
        // full register sweep also proves pointer updates
        for (int i = 0; i < 32; i++) begin
            peek(5'(i));
        end
        $display("test copies done");
        tally_and_finish();
    end
endmodule : testbench
